// ==== rtl/alsc_top.sv ====
/*
 * Card-side command length checker and response builder.
 * Assumes a byte stream with an end marker from the transmission layer,
 * and an application that serves each accepted command once.
 */
// Contract
// - low two class bits give logical channel 0 to 3
// - present Lc means exactly Lc data bytes follow, kept as data
// - present Le asks for that many response data bytes
// - Le of zero allows 1 to 256 response bytes
// - response is optional data then first and second status byte
// - normal end returns 90 00
// - pending proactive command returns 91 and its length
// - busy toolkit returns 93 00, later commands still accepted
// - warnings use 62 with 00, 81, 82 or 83
// - 63 Cx carries a retry count in the low nibble
// - execution errors are 64 00, 65 00 and 65 81
// - checking errors 67, 6B, 6D, 6E, 6F each with 00
// - other second bytes under 67 or 6F are command dependent
// - class function unsupported returns 68 with 00, 81 or 82
// - command not allowed returns 69 with 00 or 81 to 86
// - wrong parameters return 6A with 80-83 or 86-88
// - data fields carry no fixed structure here
`timescale 1ns/1ns
`include "alsc_cfg.svh"
module alsc_top
    import alsc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // command byte stream from the transmission layer
    input  wire logic       cmdValid,
    input  wire logic [7:0] cmdByte,
    input  wire logic       cmdLast,
    output logic            cmdReady,
    // response byte stream to the transmission layer
    output logic            rspValid,
    output logic      [7:0] rspByte,
    output logic            rspLast,
    input  wire logic       rspReady,
    // decoded command to the application
    output logic            cmdPending,
    output logic      [7:0] appCla,
    output logic      [7:0] appIns,
    output logic      [7:0] appP1,
    output logic      [7:0] appP2,
    output logic      [1:0] appChannel,
    output logic      [2:0] appCase,
    output logic      [7:0] appLc,
    output logic      [7:0] appLe,
    output logic            appLePresent,
    // buffer access for the application
    input  wire logic [7:0] appRdAddr,
    output logic      [7:0] appRdData,
    input  wire logic       appWrEn,
    input  wire logic [7:0] appWrAddr,
    input  wire logic [7:0] appWrData,
    // result from the application
    input  wire logic       appDone,
    input  wire alsc_kind_t appKind,
    input  wire logic [7:0] appDetail,
    input  wire logic [8:0] appLen
);
    // ==========================================================
    // state and registers
    alsc_state_t state;
    logic [8:0]  rxCnt;
    logic [7:0]  bodyFirst;
    logic [7:0]  bodyLast;
    logic [8:0]  txIdx;
    logic [8:0]  txLen;
    logic [7:0]  sw2Hold;
    logic [7:0]  sw1Hold;

    wire inRx    = (state == ALSC_S_RX);
    wire inCheck = (state == ALSC_S_CHECK);
    wire inApp   = (state == ALSC_S_APP);
    wire rxTake  = cmdValid && inRx;
    wire rspTake = rspValid && rspReady;

    // ==========================================================
    // case classification on the finished frame
    function automatic logic [8:0] widen(input logic [7:0] b);
        widen = {1'b0, b};
    endfunction : widen

    wire       tooShort = (rxCnt < `ALSC_HDR_BYTES);
    wire [8:0] nBody    = rxCnt - `ALSC_HDR_BYTES;
    wire       lcOk     = (bodyFirst != 8'h00);
    wire       isCase1  = !tooShort && (nBody == 9'h000);
    wire       isCase2  = !tooShort && (nBody == 9'h001);
    wire       isCase3  = !tooShort && lcOk && (nBody == widen(bodyFirst) + 9'h001);
    wire       isCase4  = !tooShort && lcOk && (nBody == widen(bodyFirst) + 9'h002);
    wire       lenErr   = !(isCase1 || isCase2 || isCase3 || isCase4);
    wire [2:0] caseNum  = isCase4 ? 3'h4 : isCase3 ? 3'h3 : isCase2 ? 3'h2 : 3'h1;
    wire       lePres   = isCase2 || isCase4;
    wire [7:0] leValue  = isCase2 ? bodyFirst : bodyLast;

    // ==========================================================
    // response length: absent Le gives no data, zero Le means 256
    wire [8:0] leLimit  = !appLePresent ? 9'h000 :
                          (appLe == 8'h00) ? `ALSC_LE_MAX : widen(appLe);
    wire [8:0] rspDataLen = (appLen > leLimit) ? leLimit : appLen;

    // ==========================================================
    // status encoding: locally found length errors bypass the application
    wire alsc_kind_t encKind   = inCheck ? ALSC_K_LENGTH : appKind;
    wire [7:0]       encDetail = inCheck ? `ALSC_SW2_NONE : appDetail;
    wire [7:0]       encSw1;
    wire [7:0]       encSw2;

    alsc_sw_encode u_enc (
        .kind   (encKind),
        .detail (encDetail),
        .sw1    (encSw1),
        .sw2    (encSw2)
    );

    // ==========================================================
    // shared buffer: data bytes land from index 0 whatever their meaning
    wire       rxWr   = rxTake && (rxCnt >= `ALSC_DATA_FIRST) &&
                        (rxCnt <= `ALSC_DATA_LAST);
    wire [8:0] rxAddr = rxCnt - `ALSC_DATA_FIRST;
    wire       memWe  = rxWr || (inApp && appWrEn);
    wire [7:0] memWa  = inApp ? appWrAddr : rxAddr[7:0];
    wire [7:0] memWd  = inApp ? appWrData : cmdByte;
    wire [7:0] memRa  = inApp ? appRdAddr : txIdx[7:0];

    alsc_mem #(
        .DEPTH (256),
        .AW    (8)
    ) u_mem (
        .ref_clk (ref_clk),
        .wrEn    (memWe),
        .wrAddr  (memWa),
        .wrData  (memWd),
        .rdAddr  (memRa),
        .rdData  (appRdData)
    );

    assign cmdReady   = inRx;
    assign cmdPending = inApp;

    // ==========================================================
    // receive path and header capture
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rxCnt     <= 9'h000;
            appCla    <= 8'h00;
            appIns    <= 8'h00;
            appP1     <= 8'h00;
            appP2     <= 8'h00;
            bodyFirst <= 8'h00;
            bodyLast  <= 8'h00;
        end else if (rxTake) begin
            // saturating count keeps oversized frames classed as wrong length
            if (rxCnt != `ALSC_CNT_MAX) begin
                rxCnt <= rxCnt + 9'h001;
            end
            case (rxCnt)
                9'h000:  appCla <= cmdByte;
                9'h001:  appIns <= cmdByte;
                9'h002:  appP1  <= cmdByte;
                9'h003:  appP2  <= cmdByte;
                9'h004:  bodyFirst <= cmdByte;
                default: ;
            endcase
            bodyLast <= cmdByte;
        end else if (state == ALSC_S_SW && rspTake && rspLast) begin
            rxCnt <= 9'h000;
        end
    end

    assign appChannel = appCla[1:0];

    // ==========================================================
    // controller
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state        <= ALSC_S_RX;
            appCase      <= 3'h1;
            appLc        <= 8'h00;
            appLe        <= 8'h00;
            appLePresent <= 1'b0;
            txIdx        <= 9'h000;
            txLen        <= 9'h000;
            sw1Hold      <= 8'h00;
            sw2Hold      <= 8'h00;
            rspValid     <= 1'b0;
            rspByte      <= 8'h00;
            rspLast      <= 1'b0;
        end else begin
            case (state)
                ALSC_S_RX: begin
                    if (rxTake && cmdLast) begin
                        state <= ALSC_S_CHECK;
                    end
                end
                ALSC_S_CHECK: begin
                    appCase      <= caseNum;
                    appLc        <= (isCase3 || isCase4) ? bodyFirst : 8'h00;
                    appLe        <= lePres ? leValue : 8'h00;
                    appLePresent <= lePres;
                    if (lenErr) begin
                        txLen    <= 9'h000;
                        sw2Hold  <= encSw2;
                        rspByte  <= encSw1;
                        rspValid <= 1'b1;
                        state    <= ALSC_S_SW;
                    end else begin
                        state <= ALSC_S_APP;
                    end
                end
                ALSC_S_APP: begin
                    if (appDone) begin
                        txLen   <= rspDataLen;
                        txIdx   <= 9'h000;
                        sw1Hold <= encSw1;
                        sw2Hold <= encSw2;
                        if (rspDataLen == 9'h000) begin
                            rspByte  <= encSw1;
                            rspValid <= 1'b1;
                            state    <= ALSC_S_SW;
                        end else begin
                            state <= ALSC_S_FETCH;
                        end
                    end
                end
                ALSC_S_FETCH: begin
                    state <= ALSC_S_LOAD;
                end
                ALSC_S_LOAD: begin
                    rspByte  <= appRdData;
                    rspValid <= 1'b1;
                    txIdx    <= txIdx + 9'h001;
                    state    <= ALSC_S_DATA;
                end
                ALSC_S_DATA: begin
                    if (rspTake) begin
                        if (txIdx == txLen) begin
                            rspByte <= sw1Hold;
                            state   <= ALSC_S_SW;
                        end else begin
                            rspValid <= 1'b0;
                            state    <= ALSC_S_FETCH;
                        end
                    end
                end
                ALSC_S_SW: begin
                    if (rspTake) begin
                        if (rspLast) begin
                            // back to listening whatever the status, busy included
                            rspValid <= 1'b0;
                            rspLast  <= 1'b0;
                            state    <= ALSC_S_RX;
                        end else begin
                            rspByte <= sw2Hold;
                            rspLast <= 1'b1;
                        end
                    end
                end
                default: state <= ALSC_S_RX;
            endcase
        end
    end

    // ==========================================================
    // checks
    AST_LEN_ERR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inCheck && lenErr |=> rspValid && rspByte == `ALSC_SW1_LENGTH && !rspLast)
        else $error("length error not answered with 67");
    AST_CASE3: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inCheck && isCase3 |=> inApp && appCase == 3'h3 &&
        widen(appLc) + 9'h005 == $past(rxCnt))
        else $error("case 3 data count mismatch");
    AST_NO_LC0: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inApp |-> (appCase < 3'h3) || (appLc != 8'h00))
        else $error("zero Lc accepted");
    AST_NO_LE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inApp && appDone && !appLePresent |=> state == ALSC_S_SW && txLen == 9'h000)
        else $error("data returned without Le");
    AST_LE_CAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inApp && appDone |=> txLen <= $past(leLimit) && txLen <= `ALSC_LE_MAX)
        else $error("response longer than Le allows");
    AST_SW2: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == ALSC_S_SW && rspTake && !rspLast |=> rspValid && rspLast &&
        rspByte == sw2Hold)
        else $error("second status byte missing");
    AST_NORMAL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        encKind == ALSC_K_NORMAL |-> encSw1 == 8'h90 && encSw2 == 8'h00)
        else $error("normal status wrong");
    AST_PENDING: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inApp && appDone && appKind == ALSC_K_PENDING |=> sw1Hold == 8'h91 &&
        sw2Hold == $past(appDetail))
        else $error("pending status wrong");
    AST_RETRY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        encKind == ALSC_K_RETRY |-> encSw1 == 8'h63 && encSw2 == {4'hC, encDetail[3:0]})
        else $error("retry status wrong");
    AST_REARM: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rspTake && rspLast |=> cmdReady && !rspValid && rxCnt == 9'h000)
        else $error("not ready for next command");
    AST_CHAN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rxTake && rxCnt == 9'h000 |=> appChannel == $past(cmdByte[1:0]))
        else $error("channel not from class byte");
endmodule : alsc_top

// ==== include/alsc_cfg.svh ====
/*
 * Constants of the length and status coder: header positions, length limits, status bytes.
 * Assumes inclusion by bare name from alsc_top and the status encoder.
 */
`ifndef ALSC_CFG_SVH
`define ALSC_CFG_SVH

// ==========================================================
// header and body layout
`define ALSC_HDR_BYTES    9'h004
`define ALSC_BODY_FIRST   9'h004
`define ALSC_DATA_FIRST   9'h005
`define ALSC_DATA_LAST    9'h104
`define ALSC_LE_MAX       9'h100
`define ALSC_CNT_MAX      9'h1FF

// ==========================================================
// status bytes
`define ALSC_SW1_NORMAL   8'h90
`define ALSC_SW1_PENDING  8'h91
`define ALSC_SW1_BUSY     8'h93
`define ALSC_SW1_WARN     8'h62
`define ALSC_SW1_RETRY    8'h63
`define ALSC_SW1_EXEC_NC  8'h64
`define ALSC_SW1_EXEC_CH  8'h65
`define ALSC_SW1_LENGTH   8'h67
`define ALSC_SW1_CLAFUNC  8'h68
`define ALSC_SW1_NOTALLOW 8'h69
`define ALSC_SW1_PARAM    8'h6A
`define ALSC_SW1_P1P2     8'h6B
`define ALSC_SW1_INS      8'h6D
`define ALSC_SW1_CLA      8'h6E
`define ALSC_SW1_TECH     8'h6F
`define ALSC_SW2_NONE     8'h00
`define ALSC_SW2_RETRY_HI 4'hC

`endif

// ==== include/alsc_pkg.sv ====
/*
 * Types of the length and status coder: result kinds and controller states.
 * Assumes alsc_cfg.svh is reachable on the include path.
 */
package alsc_pkg;
    // ==========================================================
    // result kinds handed in by the application
    typedef enum logic [3:0] {
        ALSC_K_NORMAL    = 4'h0,
        ALSC_K_PENDING   = 4'h1,
        ALSC_K_BUSY      = 4'h2,
        ALSC_K_WARN      = 4'h3,
        ALSC_K_RETRY     = 4'h4,
        ALSC_K_EXEC_NC   = 4'h5,
        ALSC_K_EXEC_CH   = 4'h6,
        ALSC_K_LENGTH    = 4'h7,
        ALSC_K_P1P2      = 4'h8,
        ALSC_K_INS       = 4'h9,
        ALSC_K_CLA       = 4'hA,
        ALSC_K_TECH      = 4'hB,
        ALSC_K_CLAFUNC   = 4'hC,
        ALSC_K_NOTALLOW  = 4'hD,
        ALSC_K_PARAM     = 4'hE
    } alsc_kind_t;

    // ==========================================================
    // controller states
    typedef enum logic [6:0] {
        ALSC_S_RX    = 7'h01,
        ALSC_S_CHECK = 7'h02,
        ALSC_S_APP   = 7'h04,
        ALSC_S_FETCH = 7'h08,
        ALSC_S_LOAD  = 7'h10,
        ALSC_S_DATA  = 7'h20,
        ALSC_S_SW    = 7'h40
    } alsc_state_t;
endpackage : alsc_pkg

// ==== rtl/alsc_mem.sv ====
/*
 * Byte buffer shared by command data and response data; registered read.
 * Assumes one writer and one reader per cycle, chosen by the controller.
 */
`timescale 1ns/1ns
module alsc_mem
    import alsc_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // clock
    input  wire logic          ref_clk,
    // write port
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [7:0]    wrData,
    // read port
    input  wire logic [AW-1:0] rdAddr,
    output logic      [7:0]    rdData
);
    logic [7:0] store [DEPTH];

    // no reset: contents are always written before they are read
    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
        rdData <= store[rdAddr];
    end
endmodule : alsc_mem

// ==== rtl/alsc_sw_encode.sv ====
/*
 * Status word encoder: result kind plus detail to first and second status byte.
 * Assumes the caller registers the outputs before they reach a pin.
 */
`timescale 1ns/1ns
`include "alsc_cfg.svh"
module alsc_sw_encode
    import alsc_pkg::*;
(
    // request
    input  wire alsc_kind_t kind,
    input  wire logic [7:0] detail,
    // status bytes
    output logic      [7:0] sw1,
    output logic      [7:0] sw2
);
    // ==========================================================
    // detail qualification; undefined details fall back to a safe code
    wire dWarn   = (detail >= 8'h81) && (detail <= 8'h83);
    wire dExec   = (detail == 8'h81);
    wire dCla    = (detail == 8'h81) || (detail == 8'h82);
    wire dNot    = (detail >= 8'h81) && (detail <= 8'h86);
    wire dParam  = ((detail >= 8'h80) && (detail <= 8'h83)) ||
                   ((detail >= 8'h86) && (detail <= 8'h88));

    always_comb begin
        sw2 = `ALSC_SW2_NONE;
        case (kind)
            ALSC_K_NORMAL:   sw1 = `ALSC_SW1_NORMAL;
            ALSC_K_PENDING: begin
                sw1 = `ALSC_SW1_PENDING;
                sw2 = detail;
            end
            ALSC_K_BUSY:     sw1 = `ALSC_SW1_BUSY;
            ALSC_K_WARN: begin
                sw1 = `ALSC_SW1_WARN;
                sw2 = dWarn ? detail : `ALSC_SW2_NONE;
            end
            ALSC_K_RETRY: begin
                sw1 = `ALSC_SW1_RETRY;
                sw2 = {`ALSC_SW2_RETRY_HI, detail[3:0]};
            end
            ALSC_K_EXEC_NC:  sw1 = `ALSC_SW1_EXEC_NC;
            ALSC_K_EXEC_CH: begin
                sw1 = `ALSC_SW1_EXEC_CH;
                sw2 = dExec ? detail : `ALSC_SW2_NONE;
            end
            ALSC_K_LENGTH: begin
                sw1 = `ALSC_SW1_LENGTH;
                sw2 = detail;
            end
            ALSC_K_P1P2:     sw1 = `ALSC_SW1_P1P2;
            ALSC_K_INS:      sw1 = `ALSC_SW1_INS;
            ALSC_K_CLA:      sw1 = `ALSC_SW1_CLA;
            ALSC_K_TECH: begin
                sw1 = `ALSC_SW1_TECH;
                sw2 = detail;
            end
            ALSC_K_CLAFUNC: begin
                sw1 = `ALSC_SW1_CLAFUNC;
                sw2 = dCla ? detail : `ALSC_SW2_NONE;
            end
            ALSC_K_NOTALLOW: begin
                sw1 = `ALSC_SW1_NOTALLOW;
                sw2 = dNot ? detail : `ALSC_SW2_NONE;
            end
            ALSC_K_PARAM: begin
                sw1 = `ALSC_SW1_PARAM;
                sw2 = dParam ? detail : 8'h80;
            end
            default:         sw1 = `ALSC_SW1_TECH;
        endcase
    end
endmodule : alsc_sw_encode

// ==== test/alsc_terminal.sv ====
/*
 * Terminal model: sends one command byte stream, collects the response stream.
 * Assumes it is started 1 ns after a clock edge while the card is ready.
 */
`timescale 1ns/1ns
module alsc_terminal (
    // clock
    input  wire logic       ref_clk,
    // command stream
    output logic            cmdValid,
    output logic      [7:0] cmdByte,
    output logic            cmdLast,
    input  wire logic       cmdReady,
    // response stream
    input  wire logic       rspValid,
    input  wire logic [7:0] rspByte,
    input  wire logic       rspLast,
    output logic            rspReady
);
    logic [7:0] tx [0:7];
    logic [7:0] rx [0:15];
    int         rxN = 0;
    bit         gotLast = 1'b0;
    bit         slow = 1'b0;

    initial begin
        cmdValid = 1'b0;
        cmdByte  = 8'h00;
        cmdLast  = 1'b0;
        rspReady = 1'b1;
    end

    // ==========================================================
    // command side: header first, then body; no gaps
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            cmdValid <= 1'b1;
            cmdByte  <= tx[i];
            cmdLast  <= (i == n - 1);
            @(posedge ref_clk);
            #1;
        end
        cmdValid <= 1'b0;
        cmdLast  <= 1'b0;
        cmdByte  <= ~cmdByte;  // released line must not look like a held byte
    endtask : send

    task automatic clr;
        rxN     = 0;
        gotLast = 1'b0;
    endtask : clr

    // ==========================================================
    // response side: slow mode stalls every other cycle
    always @(posedge ref_clk) begin
        if (rspValid && rspReady) begin
            rx[rxN[3:0]] <= rspByte;
            rxN          <= rxN + 1;
            gotLast      <= rspLast;
        end
        rspReady <= #1 slow ? !rspReady : 1'b1;
    end
endmodule : alsc_terminal

// ==== test/testbench.sv ====
/*
 * Bench for alsc_top: the bench plays the application, alsc_terminal the terminal.
 * Assumes alsc_pkg and alsc_cfg.svh on the include path.
 */
`timescale 1ns/1ns
module testbench
    import alsc_pkg::*;
;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       cmdValid, cmdLast, cmdReady, rspValid, rspLast, rspReady;
    logic       cmdPending, appLePresent;
    logic [7:0] cmdByte, rspByte, appCla, appIns, appP1, appP2, appLc, appLe, appRdData;
    logic [1:0] appChannel;
    logic [2:0] appCase;
    logic [7:0] appRdAddr = 8'h00;
    logic       appWrEn = 1'b0;
    logic [7:0] appWrAddr = 8'h00;
    logic [7:0] appWrData = 8'h00;
    logic       appDone = 1'b0;
    alsc_kind_t appKind = ALSC_K_NORMAL;
    logic [7:0] appDetail = 8'h00;
    logic [8:0] appLen = 9'h000;
    int         errors = 0;
    int         compares = 0;

    always #20 ref_clk = ~ref_clk;

    alsc_top dut (.ref_clk, .rst_n, .cmdValid, .cmdByte, .cmdLast, .cmdReady, .rspValid,
        .rspByte, .rspLast, .rspReady, .cmdPending, .appCla, .appIns, .appP1, .appP2,
        .appChannel, .appCase, .appLc, .appLe, .appLePresent, .appRdAddr, .appRdData,
        .appWrEn, .appWrAddr, .appWrData, .appDone, .appKind, .appDetail, .appLen);
    alsc_terminal term (.ref_clk, .cmdValid, .cmdByte, .cmdLast, .cmdReady, .rspValid,
        .rspByte, .rspLast, .rspReady);

    // ==========================================================
    // compares and closing
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_count(input int got, input int exp);
        compares++;
        if (got != exp) begin
            errors++;
            $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask : check_count

    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // command, application answer, response
    task automatic issue(input logic [63:0] v, input int n, output bit pend);
        pend = 1'b0;
        for (int i = 0; i < n; i++) begin
            term.tx[i] = v[63 - 8 * i -: 8];
        end
        term.clr;
        term.send(n);
        for (int k = 0; k < 8 && !pend; k++) begin
            @(posedge ref_clk);
            #1;
            pend = (cmdPending === 1'b1);
        end
    endtask : issue

    task automatic answer(input alsc_kind_t k, input logic [7:0] d, input int len, nwr);
        for (int i = 0; i < nwr; i++) begin
            appWrEn   <= 1'b1;
            appWrAddr <= i[7:0];
            appWrData <= 8'hA0 + i[7:0];
            @(posedge ref_clk);
            #1;
        end
        appWrEn   <= 1'b0;
        appDone   <= 1'b1;
        appKind   <= k;
        appDetail <= d;
        appLen    <= len[8:0];
        @(posedge ref_clk);
        #1;
        appDone   <= 1'b0;
    endtask : answer

    task automatic finish_rsp(input int nd, input logic [7:0] sw1, sw2);
        int k;
        for (k = 0; k < 2000 && !term.gotLast; k++) begin
            @(posedge ref_clk);
            #1;
        end
        if (k == 2000) begin
            errors++;
            $display("ERROR %0t: response never ended", $time);
            report_and_stop;
        end else begin
            check_count(term.rxN, nd + 2);
            for (int i = 0; i < nd; i++) begin
                check_byte(term.rx[i], 8'hA0 + i[7:0]);
            end
            check_byte(term.rx[nd], sw1);
            check_byte(term.rx[nd + 1], sw2);
            check_byte({7'h00, cmdReady}, 8'h01);
        end
    endtask : finish_rsp

    // ==========================================================
    // scenarios
    task automatic t_case1;
        bit p;
        issue(64'h03A4000000000000, 4, p);
        check_byte({7'h00, p}, 8'h01);
        check_byte({5'h00, appCase}, 8'h01);
        check_byte({6'h00, appChannel}, 8'h03);
        check_byte(appIns, 8'hA4);
        check_byte(appP1, 8'h00);
        check_byte(appP2, 8'h00);
        answer(ALSC_K_NORMAL, 8'h00, 0, 0);
        finish_rsp(0, 8'h90, 8'h00);
        $display("test case1 done");
    endtask : t_case1

    task automatic t_case3;
        bit p;
        issue(64'h01D6000003112233, 8, p);
        check_byte({5'h00, appCase}, 8'h03);
        check_byte(appLc, 8'h03);
        check_byte({7'h00, appLePresent}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            appRdAddr <= i[7:0];
            @(posedge ref_clk);
            #1;
            check_byte(appRdData, 8'h11 * (i[7:0] + 8'h01));
        end
        answer(ALSC_K_PENDING, 8'h12, 0, 0);
        finish_rsp(0, 8'h91, 8'h12);
        $display("test case3 done");
    endtask : t_case3

    task automatic t_case2;
        bit p;
        term.slow = 1'b1;
        issue(64'h00B0000002000000, 5, p);
        check_byte({5'h00, appCase}, 8'h02);
        check_byte(appLe, 8'h02);
        answer(ALSC_K_NORMAL, 8'h00, 4, 4);
        finish_rsp(2, 8'h90, 8'h00);
        term.slow = 1'b0;
        $display("test case2 done");
    endtask : t_case2

    task automatic t_case4;
        bit p;
        issue(64'h02880000015A0000, 7, p);
        check_byte({5'h00, appCase}, 8'h04);
        check_byte(appCla, 8'h02);
        check_byte(appLc, 8'h01);
        check_byte(appLe, 8'h00);
        check_byte({7'h00, appLePresent}, 8'h01);
        answer(ALSC_K_NORMAL, 8'h00, 3, 3);
        finish_rsp(3, 8'h90, 8'h00);
        $display("test case4 done");
    endtask : t_case4

    task automatic t_lenerr;
        bit p;
        issue(64'h00D6000002110000, 6, p);
        check_byte({7'h00, p}, 8'h00);
        finish_rsp(0, 8'h67, 8'h00);
        $display("test length error done");
    endtask : t_lenerr

    task automatic t_status;
        alsc_kind_t  kd [13] = '{ALSC_K_BUSY, ALSC_K_WARN, ALSC_K_RETRY, ALSC_K_EXEC_NC,
            ALSC_K_EXEC_CH, ALSC_K_LENGTH, ALSC_K_P1P2, ALSC_K_INS, ALSC_K_CLA, ALSC_K_TECH,
            ALSC_K_CLAFUNC, ALSC_K_NOTALLOW, ALSC_K_PARAM};
        logic [7:0]  dt [13] = '{8'h00, 8'h82, 8'hA5, 8'h00, 8'h81, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h81, 8'h86, 8'h88};
        logic [15:0] sw [13] = '{16'h9300, 16'h6282, 16'h63C5, 16'h6400, 16'h6581, 16'h6700,
            16'h6B00, 16'h6D00, 16'h6E00, 16'h6F00, 16'h6881, 16'h6986, 16'h6A88};
        bit          p;
        // busy first: every later command shows the card still accepts work
        for (int i = 0; i < 13; i++) begin
            issue(64'h00F2000000000000, 4, p);
            check_byte({7'h00, p}, 8'h01);
            answer(kd[i], dt[i], 0, 0);
            finish_rsp(0, sw[i][15:8], sw[i][7:0]);
        end
        $display("test status words done");
    endtask : t_status

    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_case1;
        t_case3;
        t_case2;
        t_case4;
        t_lenerr;
        t_status;
        report_and_stop;
    end
endmodule : testbench
